// ### src/svw_watchdog_top.sv
// Operation
// [R01] Supply low asserts resets, then holds timeout.
// [R02] Backup supply never releases reset.
// [R03] Static kick past timeout faults and resets.
// [R04] Kick edges or pulses restart watchdog.
// [R05] Floating kick disables the watchdog.
// [R06] Disabled watchdog keeps fault flag high.
// [R07] Watchdog timeout gives one reset period.
// [R08] Fault flag low until next kick edge.
// [R09] Static kick repeats reset pulses.
// [R10] Internal oscillator: 1.6 s and 200 ms.
// [R11] Timing input low: 100 ms, 1.6 s first.
// [R12] External clock: 1024, 4096, 2048 clocks.
// [R13] Capacitor oscillator scales all periods.
// [R14] Select path passes unless reset asserted.
// [R15] Close path on select high or 15 us.
// [R16] Power-up keeps select path closed.
// [R17] Closed path drives select output high.
// [R18] Power-fail flag affects nothing else.
// [R19] Supply-low flag follows supply state.
// [R20] Active-high reset inverts active-low reset.
// [R21] Status inputs are synchronous comparator outputs.
// [R22] After reset use the first period.
`timescale 1ns/1ps
module svw_watchdog_top
  import svw_pkg::*;
#(
  parameter int unsigned TimebaseCycles = TIMEBASE_CYCLES
)
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rstn,
  // Comparator outputs on this clock.
  input  wire logic supplyLow,
  input  wire logic backupSupplyActive,
  input  wire logic kickFloating,
  input  wire logic powerFailSenseInput,
  // Pins from the processor and timing network.
  input  wire logic watchdogKickInput,
  input  wire logic ceInN,
  input  wire logic oscillatorSourceSelect,
  input  wire logic oscillatorTimingInput,
  // Reset and status outputs.
  output logic      resetN_r,
  output logic      resetHigh_r,
  output logic      watchdogFaultOutputN_r,
  output logic      supplyLowFlagN_r,
  output logic      powerFailFlagOutputN_r,
  // Memory select path.
  output logic      ceOutN_r,
  output logic      ceDriveHigh_r
);

  svw_core_if bus ();

  svw_state_t       state_r;
  svw_state_t       state_nxt;
  logic [CNT_W-1:0] periodCnt_r;
  logic [CNT_W-1:0] periodCnt_nxt;
  logic             firstPeriod_r;
  logic             firstPeriod_nxt;
  logic             faultLow_r;
  logic             faultLow_nxt;
  logic [CNT_W-1:0] wdNormal;
  logic [CNT_W-1:0] wdFirst;
  logic [CNT_W-1:0] rstLimit;
  logic [CNT_W-1:0] wdLimit;
  logic             supplyDown;
  logic             wdEnabled;
  logic             restart;
  logic             resetAssert;
  logic             gateOpen_r;
  logic             grace_r;
  logic [CE_W-1:0]  ceCnt_r;

  // Pin synchronisers and kick edge detection.
  svw_input_sync uSync (
    .clock                  (clock),
    .rstn                   (rstn),
    .watchdogKickInput      (watchdogKickInput),
    .ceInN                  (ceInN),
    .oscillatorSourceSelect (oscillatorSourceSelect),
    .oscillatorTimingInput  (oscillatorTimingInput),
    .pins                   (bus.sync)
  );

  // Period timebase from the selected oscillator.
  svw_timebase #(
    .DivCycles (TimebaseCycles)
  ) uTimebase (
    .clock (clock),
    .rstn  (rstn),
    .tb    (bus.timebase)
  );

  // Period selection from the oscillator select and timing input.
  always_comb begin
    if (!bus.oscSelSync) begin
      // [R12] external clock counts
      wdNormal = EXT_WD_NORMAL_CLKS;
      wdFirst  = EXT_WD_FIRST_CLKS;
      rstLimit = EXT_RST_CLKS;
    end else if (!bus.oscInSync) begin
      // [R11] fast watchdog mode
      wdNormal = WD_FAST_TICKS;
      wdFirst  = WD_SLOW_TICKS;
      rstLimit = RST_TICKS;
    end else begin
      // [R10] internal default periods
      wdNormal = WD_SLOW_TICKS;
      wdFirst  = WD_SLOW_TICKS;
      rstLimit = RST_TICKS;
    end
  end

  // [R22] first period after reset
  assign wdLimit = firstPeriod_r ? wdFirst : wdNormal;

  // [R21] synchronous comparator inputs
  // [R02] backup forces supply-low handling
  assign supplyDown = supplyLow | backupSupplyActive;

  // [R05] floating kick disables
  assign wdEnabled = ~kickFloating;

  // Sequencer: supply, reset pulse and watchdog supervision.
  always_comb begin
    state_nxt       = state_r;
    periodCnt_nxt   = periodCnt_r;
    firstPeriod_nxt = firstPeriod_r;
    faultLow_nxt    = faultLow_r;
    restart         = 1'b0;
    // [R08] fault clears on kick
    if (bus.kickEvent) begin
      faultLow_nxt = 1'b0;
    end
    case (state_r)
      SVW_SUPPLY_LOW: begin
        periodCnt_nxt = '0;
        restart       = 1'b1;
        // [R01] start power-up timeout
        if (!supplyDown) begin
          state_nxt = SVW_RESET_PULSE;
        end
      end
      SVW_RESET_PULSE: begin
        if (bus.tick) begin
          periodCnt_nxt = periodCnt_r + 13'h0001;
          // [R07] one reset period
          if (periodCnt_r == rstLimit - 13'h0001) begin
            state_nxt       = SVW_RUN;
            periodCnt_nxt   = '0;
            firstPeriod_nxt = 1'b1;
            restart         = 1'b1;
          end
        end
      end
      SVW_RUN: begin
        if (!wdEnabled) begin
          periodCnt_nxt = '0;
          restart       = 1'b1;
        end else if (bus.kickEvent) begin
          // [R04] kick restarts timer
          periodCnt_nxt   = '0;
          firstPeriod_nxt = 1'b0;
          restart         = 1'b1;
        end else if (bus.tick) begin
          periodCnt_nxt = periodCnt_r + 13'h0001;
          // [R03] timeout faults and resets
          // [R09] repeats while kick static
          if (periodCnt_r == wdLimit - 13'h0001) begin
            state_nxt     = SVW_RESET_PULSE;
            periodCnt_nxt = '0;
            faultLow_nxt  = 1'b1;
            restart       = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = SVW_SUPPLY_LOW;
      end
    endcase
    // [R01] supply drop overrides all
    if (supplyDown) begin
      state_nxt     = SVW_SUPPLY_LOW;
      periodCnt_nxt = '0;
    end
    // [R06] disabled watchdog clears fault
    if (supplyDown || !wdEnabled) begin
      faultLow_nxt = 1'b0;
    end
  end

  assign bus.periodRestart = restart;

  // Sequencer state registers.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r       <= SVW_SUPPLY_LOW;
      periodCnt_r   <= '0;
      firstPeriod_r <= 1'b1;
      faultLow_r    <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      periodCnt_r   <= periodCnt_nxt;
      firstPeriod_r <= firstPeriod_nxt;
      faultLow_r    <= faultLow_nxt;
    end
  end

  assign resetAssert = (state_r != SVW_RUN);

  // Reset outputs, both taken from the same condition.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      resetN_r    <= 1'b0;
      resetHigh_r <= 1'b1;
    end else begin
      // [R20] outputs are exact inverses
      resetN_r    <= ~resetAssert;
      resetHigh_r <= resetAssert;
    end
  end

  // Watchdog fault output, low while a fault is latched.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      watchdogFaultOutputN_r <= 1'b1;
    end else begin
      // [R08] fault held until kick
      watchdogFaultOutputN_r <= ~faultLow_r;
    end
  end

  // Supply and power-fail status flags.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      supplyLowFlagN_r       <= 1'b1;
      powerFailFlagOutputN_r <= 1'b1;
    end else begin
      // [R19] supply flag follows supply
      supplyLowFlagN_r       <= ~supplyLow;
      // [R18] independent power-fail flag
      powerFailFlagOutputN_r <= powerFailSenseInput;
    end
  end

  // Select path gating with a short grace window at reset assertion.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gateOpen_r <= 1'b0;
      grace_r    <= 1'b0;
      ceCnt_r    <= '0;
    end else if (!resetAssert) begin
      // [R14] open during normal operation
      gateOpen_r <= 1'b1;
      grace_r    <= 1'b0;
      ceCnt_r    <= '0;
    end else if (gateOpen_r && !grace_r) begin
      // [R15] close at once if select inactive
      if (bus.ceInSyncN) begin
        gateOpen_r <= 1'b0;
      end else begin
        grace_r <= 1'b1;
        ceCnt_r <= '0;
      end
    end else if (grace_r) begin
      ceCnt_r <= ceCnt_r + 11'h001;
      // [R15] close on high or timeout
      if (bus.ceInSyncN || ceCnt_r == CE_HOLD_CYCLES - 11'h001) begin
        gateOpen_r <= 1'b0;
        grace_r    <= 1'b0;
      end
    end
  end

  // Select output: passes the input when open, held high when closed.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ceOutN_r      <= 1'b1;
      ceDriveHigh_r <= 1'b1;
    end else begin
      // [R16] closed through power-up
      // [R17] drive high while closed
      ceOutN_r      <= gateOpen_r ? bus.ceInSyncN : 1'b1;
      ceDriveHigh_r <= ~gateOpen_r;
    end
  end

endmodule // svw_watchdog_top

// ### src/svw_pkg.sv
package svw_pkg;

  // Clock rate of the block.
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Internal oscillator tick: one enable pulse per millisecond.
  localparam int unsigned TIMEBASE_US     = 1000;
  localparam int unsigned TIMEBASE_CYCLES = TIMEBASE_US * 1000 / CLK_PERIOD_NS;

  // Width of the period counter, large enough for the longest period.
  localparam int unsigned CNT_W = 13;

  // Internal oscillator periods in milliseconds.
  localparam int unsigned WD_SLOW_MS = 1600;
  localparam int unsigned WD_FAST_MS = 100;
  localparam int unsigned RST_MS     = 200;

  // The same periods as counts of internal ticks.
  localparam logic [CNT_W-1:0] WD_SLOW_TICKS =
    CNT_W'(WD_SLOW_MS * 1000 / TIMEBASE_US);
  localparam logic [CNT_W-1:0] WD_FAST_TICKS =
    CNT_W'(WD_FAST_MS * 1000 / TIMEBASE_US);
  localparam logic [CNT_W-1:0] RST_TICKS =
    CNT_W'(RST_MS * 1000 / TIMEBASE_US);

  // Periods in cycles of an external or capacitor oscillator.
  localparam logic [CNT_W-1:0] EXT_WD_NORMAL_CLKS = 13'h0400;
  localparam logic [CNT_W-1:0] EXT_WD_FIRST_CLKS  = 13'h1000;
  localparam logic [CNT_W-1:0] EXT_RST_CLKS       = 13'h0800;

  // Grace time that the memory select path stays open after reset.
  localparam int unsigned CE_W          = 11;
  localparam int unsigned CE_HOLD_NS    = 15000;
  localparam logic [CE_W-1:0] CE_HOLD_CYCLES =
    CE_W'(CE_HOLD_NS / CLK_PERIOD_NS);

  // Supervisor sequencing states.
  typedef enum logic [1:0] {
    SVW_SUPPLY_LOW,
    SVW_RESET_PULSE,
    SVW_RUN
  } svw_state_t;

endpackage

// ### src/svw_core_if.sv
`timescale 1ns/1ps
interface svw_core_if;
  // Synchronised pin levels and kick events.
  logic kickEvent;
  logic ceInSyncN;
  logic oscSelSync;
  logic oscInSync;
  // Period timebase.
  logic tick;
  logic periodRestart;

  modport sync (output kickEvent, ceInSyncN, oscSelSync, oscInSync);
  modport timebase (input oscSelSync, oscInSync, periodRestart,
                    output tick);
  modport core (input kickEvent, ceInSyncN, oscSelSync, oscInSync, tick,
                output periodRestart);
endinterface

// ### src/svw_input_sync.sv
`timescale 1ns/1ps
module svw_input_sync
  import svw_pkg::*;
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rstn,
  // Raw pins.
  input  wire logic watchdogKickInput,
  input  wire logic ceInN,
  input  wire logic oscillatorSourceSelect,
  input  wire logic oscillatorTimingInput,
  // Synchronised view.
  svw_core_if.sync  pins
);

  localparam int unsigned NPIN = 4;

  logic [NPIN-1:0] raw;
  logic [NPIN-1:0] meta_r;
  logic [NPIN-1:0] sync_r;
  logic            kickLast_r;

  assign raw = {oscillatorTimingInput, oscillatorSourceSelect,
                ceInN, watchdogKickInput};

  // Two flip-flops per pin; the first stage feeds only the second.
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : gSync
      always_ff @(posedge clock) begin
        if (!rstn) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  // Remember the settled kick level for edge detection.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      kickLast_r <= 1'b0;
    end else begin
      kickLast_r <= sync_r[0];
    end
  end

  // [R04] kick edge detect
  assign pins.kickEvent  = sync_r[0] ^ kickLast_r;
  assign pins.ceInSyncN  = sync_r[1];
  assign pins.oscSelSync = sync_r[2];
  assign pins.oscInSync  = sync_r[3];

endmodule // svw_input_sync

// ### src/svw_timebase.sv
`timescale 1ns/1ps
module svw_timebase
  import svw_pkg::*;
#(
  parameter int unsigned DivCycles = TIMEBASE_CYCLES
)
(
  // Clock and reset.
  input  wire logic    clock,
  input  wire logic    rstn,
  // Tick source.
  svw_core_if.timebase tb
);

  localparam int unsigned DIV_W = $clog2(DivCycles + 1);

  logic [DIV_W-1:0] div_r;
  logic             oscLast_r;
  logic             intTick;

  assign intTick = (div_r == DIV_W'(DivCycles - 1));

  // Internal divider, restarted so each period begins on a whole tick.
  always_ff @(posedge clock) begin
    if (!rstn || tb.periodRestart || intTick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  // Previous oscillator input level for rising edge detection.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      oscLast_r <= 1'b0;
    end else begin
      oscLast_r <= tb.oscInSync;
    end
  end

  // [R12] external clock ticks
  // [R13] capacitor oscillator ticks
  assign tb.tick = tb.oscSelSync ? intTick : (tb.oscInSync & ~oscLast_r);

endmodule // svw_timebase

// ### sim/svw_watchdog_top_properties.sv
`timescale 1ns/1ps
module svw_watchdog_props (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Status inputs.
  input wire logic supplyLow,
  input wire logic backupSupplyActive,
  input wire logic kickFloating,
  input wire logic powerFailSenseInput,
  // Outputs under watch.
  input wire logic resetN_r,
  input wire logic resetHigh_r,
  input wire logic watchdogFaultOutputN_r,
  input wire logic supplyLowFlagN_r,
  input wire logic powerFailFlagOutputN_r,
  input wire logic ceOutN_r,
  input wire logic ceDriveHigh_r
);
  logic [11:0] grace_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Counts reset cycles during which the select path is still open.
  always_ff @(posedge clock) begin
    if (!rstn || resetN_r || ceDriveHigh_r)
      grace_r <= 12'h000;
    else
      grace_r <= grace_r + 12'h001;
  end
  property p_inv; resetHigh_r == !resetN_r; endproperty
  a_inv: assert property (p_inv) else $error("reset pair differs");
  property p_sup;
    $past(rstn) && (supplyLow || backupSupplyActive) |-> ##2 !resetN_r;
  endproperty
  a_sup: assert property (p_sup) else $error("no supply reset");
  property p_low; $past(rstn) |=> supplyLowFlagN_r == !$past(supplyLow);
  endproperty
  a_low: assert property (p_low) else $error("low flag wrong");
  property p_pf;
    $past(rstn) |-> powerFailFlagOutputN_r == $past(powerFailSenseInput);
  endproperty
  a_pf: assert property (p_pf) else $error("power flag wrong");
  property p_off;
    $past(rstn) && (supplyLow || backupSupplyActive || kickFloating)
      |-> ##[1:2] watchdogFaultOutputN_r;
  endproperty
  a_off: assert property (p_off) else $error("fault not high");
  property p_flt; $fell(watchdogFaultOutputN_r) |-> !resetN_r; endproperty
  a_flt: assert property (p_flt) else $error("fault w/o reset");
  property p_drv; ceDriveHigh_r |-> ceOutN_r; endproperty
  a_drv: assert property (p_drv) else $error("closed path low");
  property p_opn;
    resetN_r && $past(resetN_r) && $past(resetN_r, 2) |-> !ceDriveHigh_r;
  endproperty
  a_opn: assert property (p_opn) else $error("path closed in run");
  property p_grc; grace_r <= 12'h5E1; endproperty
  a_grc: assert property (p_grc) else $error("grace too long");
  property p_hld; ceDriveHigh_r && !resetN_r |=> ceDriveHigh_r || resetN_r;
  endproperty
  a_hld: assert property (p_hld) else $error("path opened early");
  c_flt: cover property ($fell(watchdogFaultOutputN_r));
  c_grc: cover property (grace_r == 12'h5DC);
  c_rel: cover property ($rose(resetN_r));
endmodule // svw_watchdog_props

bind svw_watchdog_top svw_watchdog_props u_props (.clock, .rstn,
  .supplyLow, .backupSupplyActive, .kickFloating, .powerFailSenseInput,
  .resetN_r, .resetHigh_r, .watchdogFaultOutputN_r, .supplyLowFlagN_r,
  .powerFailFlagOutputN_r, .ceOutN_r, .ceDriveHigh_r);

// ### sim/svw_cpu_model.sv
`timescale 1ns/1ps
module svw_cpu_model (
  // Clock.
  input wire logic clock,
  // Controls from the bench.
  input wire logic kickEn,
  input wire logic ceReq,
  // Pins toward the supervisor.
  output logic     kick,
  output logic     ceInN
);
  logic [5:0] div_r;
  // Start quiet so the kick pin has a level at time zero.
  initial begin
    kick = 1'b0;
    div_r = 6'h00;
  end
  // toggle kick pin
  // Each toggle holds 50 cycles, far above the shortest pulse allowed.
  always @(posedge clock) begin
    div_r <= (div_r == 6'h31) ? 6'h00 : div_r + 6'h01;
    if (kickEn && div_r == 6'h31)
      kick <= ~kick;
  end
  // The processor selects memory by pulling the select low.
  assign ceInN = !ceReq;
endmodule // svw_cpu_model

// ### sim/tb_svw_watchdog_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", nm, e, a); end end
module tb_svw_watchdog_top;
  logic clock, rstn, supplyLow, backupSupplyActive, kickFloating, power_fail_sense_input;
  logic sel, tin, extMode, fastMode, kickEn, ceReq, kick, ceInN;
  logic resetN, resetHigh, fault, lowFlag, pfFlag, ceOut, ceDrv;
  int   n_mismatch, checks_done, n;
  // Rows: power-fail in, select request, flag out, select out.
  logic [3:0] rows [4] = '{4'hE, 4'h4, 4'h1, 4'hB};

  svw_watchdog_top #(.TimebaseCycles(10)) uut (
    .clock(clock), .rstn(rstn), .supplyLow(supplyLow),
    .backupSupplyActive(backupSupplyActive), .kickFloating(kickFloating),
    .powerFailSenseInput(power_fail_sense_input), .watchdogKickInput(kick), .ceInN(ceInN),
    .oscillatorSourceSelect(sel), .oscillatorTimingInput(tin),
    .resetN_r(resetN), .resetHigh_r(resetHigh),
    .watchdogFaultOutputN_r(fault), .supplyLowFlagN_r(lowFlag),
    .powerFailFlagOutputN_r(pfFlag), .ceOutN_r(ceOut),
    .ceDriveHigh_r(ceDrv));
  svw_cpu_model cpu (.clock(clock), .kickEn(kickEn), .ceReq(ceReq),
    .kick(kick), .ceInN(ceInN));

  always #5 clock = ~clock;
  // Timing input is a free clock in external mode, else a level:
  // high for the default periods, low for the fast watchdog mode.
  always @(posedge clock)
    tin <= extMode ? ~tin : ~fastMode;

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask
  // Waits, bounded, until reset or fault shows the wanted level.
  task automatic waitSig(input bit f, input logic v, output int c);
    c = 0;
    while ((f ? fault : resetN) !== v && c < 20000) begin
      @(posedge clock);
      #1;
      c++;
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Cuts a hang short at 1 ms, less than a fifth past the expected run length.
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end

  initial begin
    clock = 0; rstn = 0; supplyLow = 0; backupSupplyActive = 0;
    kickFloating = 0; power_fail_sense_input = 1; sel = 1; tin = 1; extMode = 0;
    fastMode = 0; kickEn = 0; ceReq = 0; n_mismatch = 0; checks_done = 0;
    tick(2);
    rstn <= 1'b1;
    ceReq <= 1'b1;
    #1;
    `CHK("resetN", 1'b0, resetN)
    `CHK("resetHigh", 1'b1, resetHigh)
    `CHK("ceDrv", 1'b1, ceDrv)
    tick(1000);
    #1;
    `CHK("ceOut", 1'b1, ceOut)
    waitSig(0, 1'b1, n);
    `CHK("pwrup", 1'b1, n > 994 && n < 1016)
    tick(1);
    kickEn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      power_fail_sense_input <= rows[i][3];
      ceReq <= rows[i][2];
      tick(5);
      #1;
      `CHK("pfFlag", rows[i][1], pfFlag)
      `CHK("ceOut", rows[i][0], ceOut)
      `CHK("resetN", 1'b1, resetN)
    end
    // Kicks keep reset away well past the first period.
    tick(17000);
    #1;
    `CHK("resetN", 1'b1, resetN)
    `CHK("fault", 1'b1, fault)
    tick(1);
    kickEn <= 1'b0;
    waitSig(1, 1'b0, n);
    `CHK("wdPeriod", 1'b1, n > 15940 && n < 16010)
    `CHK("resetN", 1'b0, resetN)
    waitSig(0, 1'b1, n);
    `CHK("rstPulse", 1'b1, n > 1990 && n < 2010)
    tick(100);
    #1;
    `CHK("fault", 1'b0, fault)
    tick(1);
    kickEn <= 1'b1;
    tick(60);
    #1;
    `CHK("fault", 1'b1, fault)
    // Fast mode: the kicked timer now runs the short normal period.
    tick(1);
    fastMode <= 1'b1;
    kickEn <= 1'b0;
    waitSig(1, 1'b0, n);
    `CHK("fastPeriod", 1'b1, n > 950 && n < 1010)
    waitSig(0, 1'b1, n);
    `CHK("fastRst", 1'b1, n > 1990 && n < 2010)
    tick(1200);
    #1;
    `CHK("resetN", 1'b1, resetN)
    tick(1);
    fastMode <= 1'b0;
    kickFloating <= 1'b1;
    tick(15500);
    #1;
    `CHK("fault", 1'b1, fault)
    `CHK("resetN", 1'b1, resetN)
    tick(1);
    kickFloating <= 1'b0;
    kickEn <= 1'b1;
    ceReq <= 1'b1;
    tick(5);
    supplyLow <= 1'b1;
    tick(3);
    #1;
    `CHK("resetN", 1'b0, resetN)
    `CHK("lowFlag", 1'b0, lowFlag)
    `CHK("fault", 1'b1, fault)
    tick(1390);
    #1;
    `CHK("ceOut", 1'b0, ceOut)
    tick(120);
    #1;
    `CHK("ceOut", 1'b1, ceOut)
    `CHK("ceDrv", 1'b1, ceDrv)
    tick(1);
    supplyLow <= 1'b0;
    backupSupplyActive <= 1'b1;
    tick(20);
    #1;
    `CHK("resetN", 1'b0, resetN)
    tick(1);
    backupSupplyActive <= 1'b0;
    waitSig(0, 1'b1, n);
    `CHK("rstBack", 1'b1, n > 1994 && n < 2016)
    tick(1);
    sel <= 1'b0;
    extMode <= 1'b1;
    kickEn <= 1'b0;
    supplyLow <= 1'b1;
    tick(5);
    supplyLow <= 1'b0;
    waitSig(0, 1'b1, n);
    `CHK("extRst", 1'b1, n > 4086 && n < 4112)
    waitSig(1, 1'b0, n);
    `CHK("extFirst", 1'b1, n > 8180 && n < 8206)
    // Static kick: the pulse and the next timeout repeat.
    waitSig(0, 1'b1, n);
    `CHK("extPulse", 1'b1, n > 4086 && n < 4106)
    waitSig(0, 1'b0, n);
    `CHK("repeat", 1'b1, n > 8180 && n < 8206)
    summarize();
  end
endmodule // tb_svw_watchdog_top
